// ==== hdl/cdr_map.svh ====
// register offsets, field positions, reset values for the diag result block
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH

// ********************************
// register offsets
// ********************************
`define CDR_OFS_LAUNCH      16'hba1b
`define CDR_OFS_XPAIR_OFF   16'hba1c
`define CDR_OFS_PAIR0       16'hba1d
`define CDR_OFS_PAIR1       16'hba1e
`define CDR_OFS_PAIR2       16'hba1f
`define CDR_OFS_IRQ_STATUS  16'hba30
`define CDR_OFS_IRQ_MASK    16'hba31

// ********************************
// field positions and widths
// ********************************
`define CDR_BIT_LAUNCH      0
`define CDR_BIT_XPAIR_OFF   0
`define CDR_FLAG_W          11
`define CDR_IRQ_W           3
`define CDR_IRQ_DONE        0
`define CDR_IRQ_FAULT       1
`define CDR_IRQ_REFUSED     2

// ********************************
// reset values
// ********************************
`define CDR_RST_WORD        16'h0000
`define CDR_RST_IRQ         3'h0

`endif

// ==== hdl/cdr_pkg.sv ====
// types shared by the cable diag result register block
`include "cdr_map.svh"

package cdr_pkg;

  // per-pair flags as reported by the diagnostic engine, msb first
  typedef struct packed {
    logic       activity_seen;  // unknown activity on the pair
    logic [2:0] imp_short_to;   // impedance shorts to the other pairs
    logic       imp_mismatch;   // impedance mismatch on the pair
    logic [2:0] short_to;       // direct shorts to the other pairs
    logic       shorted;        // short on the pair itself
    logic       open_circuit;   // open on the pair
    logic       terminated_ok;  // pair well terminated
  } cdr_pair_flags_t;

  // launch sequencer states
  typedef enum logic {
    CDR_IDLE,
    CDR_RUN
  } cdr_state_t;

  // pad a flag set into a 16-bit register word, upper bits zero
  function automatic logic [15:0] cdr_word(input cdr_pair_flags_t f);
    cdr_word = {5'h00, f};
  endfunction

endpackage : cdr_pkg

// ==== hdl/cdr_capture.sv ====
// result capture for pairs 0 to 2 with cross-pair suppression
`timescale 1ns/1ps
`default_nettype none

module cdr_capture
  import cdr_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 capture_in,
  input  wire logic                 xpair_off_in,
  input  wire cdr_pair_flags_t [2:0] raw_in,
  output var  cdr_pair_flags_t [2:0] result_out,
  output var  logic                 fault_out
);

  cdr_pair_flags_t [2:0] next_result;  // filtered engine report

  // strip cross-pair flags when checking is suppressed
  always_comb begin
    next_result = raw_in;
    for (int i = 0; i < 3; i++) begin
      if (xpair_off_in) begin
        next_result[i].imp_short_to = 3'h0;
        next_result[i].short_to     = 3'h0;
      end
    end
  end

  // all words load together, then hold until the next run
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_out <= '0;
    end else if (capture_in) begin
      result_out <= next_result;
    end
  end

  // any fault flag left in the filtered report, sampled with the load
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fault_out <= 1'b0;
    end else if (capture_in) begin
      fault_out <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        if (|next_result[i][`CDR_FLAG_W-1:1]) begin
          fault_out <= 1'b1;
        end
      end
    end
  end

endmodule // cdr_capture

`default_nettype wire

// ==== hdl/cdr_irq.sv ====
// sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none

module cdr_irq
  import cdr_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  input  wire logic [`CDR_IRQ_W-1:0] set_in,
  input  wire logic                 clear_in,
  input  wire logic                 mask_wr_in,
  input  wire logic [`CDR_IRQ_W-1:0] mask_in,
  output var  logic [`CDR_IRQ_W-1:0] status_out,
  output var  logic [`CDR_IRQ_W-1:0] mask_out,
  output var  logic                 irq_out
);

  // sticky bits: a set in the clearing cycle survives the clear
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_out <= `CDR_RST_IRQ;
    end else begin
      status_out <= (clear_in ? `CDR_RST_IRQ : status_out) | set_in;
    end
  end

  // mask register, one means enabled
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask_out <= `CDR_RST_IRQ;
    end else if (mask_wr_in) begin
      mask_out <= mask_in;
    end
  end

  // registered level, lags the status by one cycle
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_out & mask_out);
    end
  end

endmodule // cdr_irq

`default_nettype wire

// ==== hdl/cdr_regs.sv ====
// top: cable diagnostic control and per-pair result register bank
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module cdr_regs
  import cdr_pkg::*;
(
  // ********************************
  // clock and reset
  // ********************************
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  // ********************************
  // register port
  // ********************************
  input  wire logic [15:0]          reg_addr_in,
  input  wire logic [15:0]          reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output var  logic [15:0]          reg_rdata_out,
  // ********************************
  // transceiver state
  // ********************************
  input  wire logic                 phy_standby_in,
  input  wire logic                 link_allow_in,
  // ********************************
  // diagnostic engine
  // ********************************
  input  wire logic                 diag_done_in,
  input  wire cdr_pair_flags_t [2:0] diag_flags_in,
  output var  logic                 diag_launch_out,
  output var  logic                 cross_pair_check_off_out,
  // ********************************
  // interrupt
  // ********************************
  output var  logic                 irq_out
);

  // ********************************
  // declarations
  // ********************************
  cdr_state_t            state;             // launch sequencer
  cdr_state_t            next_state;        // sequencer next value
  logic                  diag_launch;       // launch bit
  logic                  cross_pair_check_off; // suppression bit
  cdr_pair_flags_t [2:0] pair_result;       // held result flags
  logic                  fault_seen;        // last run found a fault
  logic                  run_done;          // engine finished a run
  logic                  launch_wr;         // write hits the launch word
  logic                  launch_req;        // software asks for a run
  logic                  launch_ok;         // transceiver ready for a run
  logic                  launch_refused;    // request turned away
  logic                  fault_evt;         // fault reported, one cycle late
  logic                  done_q;            // completion, delayed one cycle
  logic [`CDR_IRQ_W-1:0] irq_set;           // events into the status
  logic [`CDR_IRQ_W-1:0] irq_status;        // sticky status
  logic [`CDR_IRQ_W-1:0] irq_mask;          // interrupt enables
  logic                  irq_clear;         // read of the status word
  logic                  mask_wr;           // write to the mask word
  logic [15:0]           next_rdata;        // decoded read value

  // ********************************
  // write decode
  // ********************************

  // a write to the launch word with bit 0 set is a run request
  assign launch_wr  = reg_wr_in && (reg_addr_in == `CDR_OFS_LAUNCH);
  assign launch_req = launch_wr && reg_wdata_in[`CDR_BIT_LAUNCH];

  assign launch_ok  = phy_standby_in && !link_allow_in;

  // a request while a run is active is absorbed, not refused
  assign launch_refused = launch_req && !launch_ok && (state == CDR_IDLE);

  // only a completion during a run counts; stray ones are dropped
  assign run_done = diag_done_in && (state == CDR_RUN);

  // mask write decode
  assign mask_wr = reg_wr_in && (reg_addr_in == `CDR_OFS_IRQ_MASK);

  // status clears on the read strobe itself
  assign irq_clear = reg_rd_in && (reg_addr_in == `CDR_OFS_IRQ_STATUS);

  // ********************************
  // suppression control
  // ********************************

  // only bit 0 is stored; the rest of the word is dropped
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cross_pair_check_off <= 1'b0;
    end else if (reg_wr_in && (reg_addr_in == `CDR_OFS_XPAIR_OFF)) begin
      cross_pair_check_off <= reg_wdata_in[`CDR_BIT_XPAIR_OFF];
    end
  end

  // engine sees the bit straight from the flop
  assign cross_pair_check_off_out = cross_pair_check_off;

  // ********************************
  // launch sequencer
  // ********************************

  // next state: idle until an accepted request, run until done
  always_comb begin
    next_state = state;
    unique case (state)
      CDR_IDLE: begin
        if (launch_req && launch_ok) begin
          next_state = CDR_RUN;
        end
      end
      CDR_RUN: begin
        if (diag_done_in) begin
          next_state = CDR_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= CDR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // launch bit tracks the run; software cannot abort a run by
  // writing zero, which keeps result words consistent
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      diag_launch <= 1'b0;
    end else begin
      diag_launch <= (next_state == CDR_RUN);
    end
  end

  // launch level to the engine, high for the whole run
  assign diag_launch_out = diag_launch;

  // ********************************
  // result capture
  // ********************************

  // filters cross flags and holds the words between runs
  cdr_capture u_capture (
    .ref_clk_in   (ref_clk_in),
    .resetn_in    (resetn_in),
    .capture_in   (run_done),
    .xpair_off_in (cross_pair_check_off),
    .raw_in       (diag_flags_in),
    .result_out   (pair_result),
    .fault_out    (fault_seen)
  );

  // ********************************
  // interrupt events
  // ********************************

  // the fault flag is valid one cycle after the load, so the done
  // pulse is delayed to line the two events up
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_q <= 1'b0;
    end else begin
      done_q <= run_done;
    end
  end

  // fault event follows the load that produced it
  assign fault_evt = done_q && fault_seen;

  // event vector in status layout
  always_comb begin
    irq_set                   = `CDR_RST_IRQ;
    irq_set[`CDR_IRQ_DONE]    = done_q;
    irq_set[`CDR_IRQ_FAULT]   = fault_evt;
    irq_set[`CDR_IRQ_REFUSED] = launch_refused;
  end

  // sticky status, mask and interrupt level
  cdr_irq u_irq (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .set_in     (irq_set),
    .clear_in   (irq_clear),
    .mask_wr_in (mask_wr),
    .mask_in    (reg_wdata_in[`CDR_IRQ_W-1:0]),
    .status_out (irq_status),
    .mask_out   (irq_mask),
    .irq_out    (irq_out)
  );

  // ********************************
  // read decode
  // ********************************

  // unmapped offsets and reserved bits read as zero
  always_comb begin
    next_rdata = `CDR_RST_WORD;
    unique case (reg_addr_in)
      `CDR_OFS_LAUNCH: begin
        next_rdata[`CDR_BIT_LAUNCH] = diag_launch;
      end
      `CDR_OFS_XPAIR_OFF: begin
        next_rdata[`CDR_BIT_XPAIR_OFF] = cross_pair_check_off;
      end
      `CDR_OFS_PAIR0: begin
        next_rdata = cdr_word(pair_result[0]);
      end
      `CDR_OFS_PAIR1: begin
        next_rdata = cdr_word(pair_result[1]);
      end
      `CDR_OFS_PAIR2: begin
        next_rdata = cdr_word(pair_result[2]);
      end
      `CDR_OFS_IRQ_STATUS: begin
        next_rdata[`CDR_IRQ_W-1:0] = irq_status;
      end
      `CDR_OFS_IRQ_MASK: begin
        next_rdata[`CDR_IRQ_W-1:0] = irq_mask;
      end
      default: begin
        next_rdata = `CDR_RST_WORD;
      end
    endcase
  end

  // good at bit 0
  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= `CDR_RST_WORD;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= `CDR_RST_WORD;
    end
  end

endmodule // cdr_regs

`default_nettype wire

// ==== bench/cdr_regs_sva.sv ====
// checker for the cable diag result register bank
`timescale 1ns/1ps
`default_nettype none
module cdr_regs_sva
  import cdr_pkg::*;
(
  input wire logic                  ref_clk_in,
  input wire logic                  resetn_in,
  input wire logic [15:0]           reg_addr_in,
  input wire logic [15:0]           reg_wdata_in,
  input wire logic                  reg_wr_in,
  input wire logic                  reg_rd_in,
  input wire logic [15:0]           reg_rdata_out,
  input wire logic                  phy_standby_in,
  input wire logic                  link_allow_in,
  input wire logic                  diag_done_in,
  input wire cdr_pair_flags_t [2:0] diag_flags_in,
  input wire logic                  diag_launch_out,
  input wire logic                  cross_pair_check_off_out,
  input wire logic                  irq_out
);
  // ********************************
  // helper and properties
  // ********************************
  logic [10:0] exp0;  // expected pair 0 flags, cross bits cut when suppressed
  logic        lw;    // launch write with bit 0 set while idle
  assign lw = reg_wr_in && reg_addr_in == 16'hba1b && reg_wdata_in[0] && !diag_launch_out;
  // shadow only loads on a completion inside a run, as the bank should
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      exp0 <= 11'h000;
    end else if (diag_done_in && diag_launch_out) begin
      exp0 <= diag_flags_in[0] & (cross_pair_check_off_out ? 11'h447 : 11'h7ff);
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data not zero outside read slot");
  a_rsv_zero: assert property (reg_rd_in |=> reg_rdata_out[15:11] == 5'h00)
    else $error("reserved bits read nonzero");
  a_xpair_wr: assert property (reg_wr_in && reg_addr_in == 16'hba1c
    |=> cross_pair_check_off_out == $past(reg_wdata_in[0])) else $error("suppression bit wrong");
  a_xpair_hold: assert property (!(reg_wr_in && reg_addr_in == 16'hba1c)
    |=> $stable(cross_pair_check_off_out)) else $error("suppression bit moved");
  a_launch_go: assert property (lw && phy_standby_in && !link_allow_in |=> diag_launch_out)
    else $error("launch not taken");
  a_launch_refuse: assert property (lw && (!phy_standby_in || link_allow_in)
    |=> !diag_launch_out [*2]) else $error("launch taken outside standby");
  a_launch_clear: assert property (diag_launch_out && diag_done_in |=> !diag_launch_out)
    else $error("launch did not self clear");
  a_launch_hold: assert property (diag_launch_out && !diag_done_in |=> diag_launch_out)
    else $error("launch dropped early");
  a_pair0_word: assert property (reg_rd_in && reg_addr_in == 16'hba1d
    |=> reg_rdata_out == {5'h00, $past(exp0)}) else $error("pair 0 word wrong");
  c_run_done: cover property (diag_launch_out && diag_done_in);
  c_refused: cover property (lw && !phy_standby_in);
  c_irq: cover property ($rose(irq_out));
endmodule // cdr_regs_sva
bind cdr_regs cdr_regs_sva chk (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .phy_standby_in(phy_standby_in),
  .link_allow_in(link_allow_in), .diag_done_in(diag_done_in), .diag_flags_in(diag_flags_in),
  .diag_launch_out(diag_launch_out), .cross_pair_check_off_out(cross_pair_check_off_out),
  .irq_out(irq_out));
`default_nettype wire

// ==== bench/cdr_cable_model.sv ====
// diagnostic engine and cable stand-in at the far side of the bank
`timescale 1ns/1ps
`default_nettype none
module cdr_cable_model
  import cdr_pkg::*;
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  launch_in,  // run in progress
  input  wire logic [7:0]            delay_in,   // cycles until completion
  input  wire cdr_pair_flags_t [2:0] pattern_in, // what the cable reports
  output logic                       done_out,
  output cdr_pair_flags_t [2:0]      flags_out
);
  logic [7:0] cnt;  // cycles since launch
  // run only while launched, one done pulse per run
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt      <= 8'h00;
      done_out <= 1'b0;
    end else if (!launch_in) begin
      cnt      <= 8'h00;
      done_out <= 1'b0;
    end else begin
      cnt      <= cnt + 8'h01;
      done_out <= (cnt == delay_in);
    end
  end
  // flags are junk outside the done cycle so stale values cannot pass
  assign flags_out = done_out ? pattern_in : ~pattern_in;
endmodule // cdr_cable_model
`default_nettype wire

// ==== bench/tb_cable_diag_result_regs.sv ====
// self-checking bench for the cable diag result register bank
`timescale 1ns/1ps
`default_nettype none
module tb_cable_diag_result_regs;
  import cdr_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, stby = 1'b1, lnk = 1'b0;
  logic [15:0] addr = 16'h0000, wdat = 16'h0000, rdat;
  logic launch, xoff, irq, done;
  logic [7:0] dly = 8'h01;
  cdr_pair_flags_t [2:0] pat = {11'h4aa, 11'h001, 11'h7fe}, fl;
  int err_total = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  cdr_regs uut (.ref_clk_in(clk), .resetn_in(rstn), .reg_addr_in(addr), .reg_wdata_in(wdat),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .phy_standby_in(stby),
    .link_allow_in(lnk), .diag_done_in(done), .diag_flags_in(fl), .diag_launch_out(launch),
    .cross_pair_check_off_out(xoff), .irq_out(irq));
  cdr_cable_model cable (.ref_clk_in(clk), .resetn_in(rstn), .launch_in(launch),
    .delay_in(dly), .pattern_in(pat), .done_out(done), .flags_out(fl));
  // ********************************
  // bus tasks and compares
  // ********************************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk); addr <= a; wdat <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic run_wait;
    wr_reg(16'hba1b, 16'h0001);
    // let the launch flop settle before polling it
    @(posedge clk);
    for (int i = 0; i < 200 && launch !== 1'b0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // rows: address, write first, write data, expected read
  typedef struct packed {logic [15:0] a; logic w; logic [15:0] d; logic [15:0] e;} cdr_row_t;
  cdr_row_t rows [11] = '{
    '{16'hba1b, 1'b0, 16'h0, 16'h0000}, '{16'hba1c, 1'b0, 16'h0, 16'h0000},
    '{16'hba1d, 1'b0, 16'h0, 16'h0000}, '{16'hba1e, 1'b0, 16'h0, 16'h0000},
    '{16'hba1f, 1'b0, 16'h0, 16'h0000}, '{16'hba30, 1'b0, 16'h0, 16'h0000},
    '{16'hba1c, 1'b1, 16'hffff, 16'h0001}, '{16'hba1c, 1'b1, 16'hfffe, 16'h0000},
    '{16'hba1d, 1'b1, 16'hffff, 16'h0000}, '{16'hba31, 1'b1, 16'h0007, 16'h0007},
    '{16'hba20, 1'b1, 16'hffff, 16'h0000}};
  logic [15:0] v;
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, v); chk16(v, rows[i].e);
    end
    $display("test table done");
    // full run, cross checks on, prompt engine
    run_wait();
    rd_reg(16'hba1d, v); chk16(v, 16'h07fe);
    rd_reg(16'hba1e, v); chk16(v, 16'h0001);
    rd_reg(16'hba1f, v); chk16(v, 16'h04aa);
    chk1(irq, 1'b1);
    rd_reg(16'hba30, v); chk16(v, 16'h0003);
    repeat (2) @(posedge clk); chk1(irq, 1'b0);
    $display("test run done");
    // suppressed cross checks, slow engine
    wr_reg(16'hba1c, 16'h0001); dly <= 8'd40;
    #1 chk1(xoff, 1'b1);
    run_wait();
    rd_reg(16'hba1d, v); chk16(v, 16'h0446);
    rd_reg(16'hba1f, v); chk16(v, 16'h0402);
    $display("test suppress done");
    // refused launch with irq masked off
    wr_reg(16'hba31, 16'h0000); stby <= 1'b0;
    wr_reg(16'hba1b, 16'h0001); chk1(launch, 1'b0);
    repeat (3) @(posedge clk); chk1(irq, 1'b0);
    rd_reg(16'hba30, v); chk16(v, 16'h0007);
    $display("test refuse done");
    // reset in mid run clears the results
    stby <= 1'b1; wr_reg(16'hba1b, 16'h0001);
    #1 chk1(launch, 1'b1);
    rstn <= 1'b0; repeat (3) @(posedge clk); rstn <= 1'b1;
    chk1(launch, 1'b0);
    rd_reg(16'hba1d, v); chk16(v, 16'h0000);
    rd_reg(16'hba1c, v); chk16(v, 16'h0000);
    $display("test reset done");
    complete_run();
  end
  // watchdog well past the roughly 150 cycles the tests need
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
endmodule // tb_cable_diag_result_regs
`default_nettype wire
